// file: rsc_reset_state_controller.v
`include "rsc_consts.vh"

// Functional notes
// R1: the time-out and power-down flags live in the status register and follow reset type and mode.
// R2: a power-on reset clears both the time-out and power-down flags.
// R3: a pin or low-voltage reset in fast or slow mode leaves both flags unchanged.
// R4: a watchdog reset in fast or slow mode sets time-out and leaves power-down unchanged.
// R5: a watchdog reset in idle or sleep mode sets both flags.
// R6: after power-on every interrupt source is disabled until software enables it.
// R7: after power-on the watchdog and time-base counters clear and the watchdog starts counting.
// R8: after power-on every timer module is switched off.
// R9: after power-on every port pin is an input.
// R10: after power-on the stack pointer indicates the top of the call stack.
// R11: most registers take fixed defaults, but a watchdog reset in idle or sleep retains them; code retains only int enable, timer on, port dir, WDT ctrl.
// R12: reset cause and power mode form a selector choosing default or retained value.
// R13: a watchdog reset in idle or sleep clears program counter and stack pointer.
module rsc_reset_state_controller (
    input  wire       I_SYS_CLK,
    input  wire       I_RST,
    input  wire       I_POR,
    input  wire       I_EXT_PIN_RST,
    input  wire       I_LOW_VOLTAGE_RST,
    input  wire       I_WDT_TIMEOUT,
    input  wire       I_LOW_POWER_MODE,
    input  wire       I_STATUS_WE,
    input  wire [7:0] I_STATUS_WDATA,
    input  wire       I_INT_EN_WE,
    input  wire [7:0] I_INT_EN_WDATA,
    input  wire       I_TIMER_ON_WE,
    input  wire [7:0] I_TIMER_ON_WDATA,
    input  wire       I_PORT_DIR_WE,
    input  wire [7:0] I_PORT_DIR_WDATA,
    input  wire       I_OPT_MAP_WE,
    input  wire [7:0] I_OPT_MAP_WDATA,
    input  wire       I_PC_LOAD,
    input  wire [7:0] I_PC_WDATA,
    input  wire       I_SP_LOAD,
    input  wire [3:0] I_SP_WDATA,
    output reg  [7:0] O_STATUS,
    output reg        O_TIMEOUT_FLAG,
    output reg        O_POWERDOWN_FLAG,
    output reg  [7:0] O_INT_ENABLE,
    output reg  [3:0] O_INTERRUPT_CONTROL_FOUR,
    output reg  [7:0] O_TIMER_ON,
    output reg  [7:0] O_PORT_DIR,
    output reg  [7:0] O_OPTION_MAPPING_CONTROL,
    output reg  [7:0] O_PROGRAM_COUNTER_LOW,
    output reg  [3:0] O_STACK_PTR,
    output reg  [7:0] O_WATCHDOG_TIMER_CTRL,
    output reg        O_WDT_CLEAR,
    output reg  [1:0] O_RESET_SEL
);

    // two-flop synchronisers for the asynchronous reset sources
    reg  [3:0] cause_meta_ff;
    reg  [3:0] cause_sync_ff;
    reg  [3:0] cause_prev_ff;
    reg        mode_meta_ff;
    reg        mode_sync_ff;

    // decoded event and selector
    wire [3:0] cause_rise;
    reg  [3:0] evt;
    reg  [1:0] nxt_sel;

    // selector: default for all resets except watchdog in idle/sleep
    function [1:0] rsc_sel;
        input [3:0] ev;
        input       low_pwr;
        begin
            if (ev == `RSC_CAUSE_WDT && low_pwr) begin
                rsc_sel = `RSC_SEL_RETAIN;
            end else begin
                rsc_sel = `RSC_SEL_DEFAULT;
            end
        end
    endfunction

    // cause and mode synchronisers with one cycle of edge history
    always @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            cause_meta_ff <= `RSC_ZERO4;
            cause_sync_ff <= `RSC_ZERO4;
            cause_prev_ff <= `RSC_ZERO4;
            mode_meta_ff  <= 1'b0;
            mode_sync_ff  <= 1'b0;
        end else begin
            cause_meta_ff <= {I_WDT_TIMEOUT, I_LOW_VOLTAGE_RST, I_EXT_PIN_RST, I_POR};
            cause_sync_ff <= cause_meta_ff;
            cause_prev_ff <= cause_sync_ff;
            mode_meta_ff  <= I_LOW_POWER_MODE;
            mode_sync_ff  <= mode_meta_ff;
        end
    end

    // a held cause counts once, on its rising edge
    assign cause_rise = cause_sync_ff & ~cause_prev_ff;

    // priority among simultaneous causes: power-on, pin, low voltage, watchdog
    always @* begin
        if (cause_rise[0]) begin
            evt = `RSC_CAUSE_POR;
        end else if (cause_rise[1]) begin
            evt = `RSC_CAUSE_PIN;
        end else if (cause_rise[2]) begin
            evt = `RSC_CAUSE_LVR;
        end else if (cause_rise[3]) begin
            evt = `RSC_CAUSE_WDT;
        end else begin
            evt = `RSC_ZERO4;
        end
        nxt_sel = (evt == `RSC_ZERO4) ? `RSC_SEL_NONE : rsc_sel(evt, mode_sync_ff); // see R12
    end

    // selector qualifiers shared by the register groups
    wire       any_evt;
    wire       apply_dflt;
    wire       sw_open;

    assign any_evt    = (nxt_sel != `RSC_SEL_NONE);
    assign apply_dflt = (nxt_sel == `RSC_SEL_DEFAULT);
    assign sw_open    = (nxt_sel == `RSC_SEL_NONE); // reset wins over a same-cycle write

    // one-cycle selector pulse and watchdog restart
    always @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_RESET_SEL <= `RSC_SEL_NONE;
            O_WDT_CLEAR <= 1'b0;
        end else begin
            O_RESET_SEL <= nxt_sel; // see R12
            O_WDT_CLEAR <= apply_dflt; // see R7
        end
    end

    // status register and its flag copies
    always @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_STATUS         <= `RSC_STAT_POR;
            O_TIMEOUT_FLAG   <= 1'b0;
            O_POWERDOWN_FLAG <= 1'b0;
        end else begin
            case (evt)
                `RSC_CAUSE_POR: begin
                    O_STATUS         <= `RSC_STAT_POR; // see R2
                    O_TIMEOUT_FLAG   <= 1'b0; // see R2
                    O_POWERDOWN_FLAG <= 1'b0; // see R2
                end
                `RSC_CAUSE_WDT: begin
                    // hardware set wins over a software write in this cycle
                    O_STATUS[`RSC_STAT_TO_BIT] <= 1'b1; // see R4
                    O_TIMEOUT_FLAG <= 1'b1; // see R4
                    if (mode_sync_ff) begin
                        O_STATUS[`RSC_STAT_PDF_BIT] <= 1'b1; // see R5
                        O_POWERDOWN_FLAG <= 1'b1; // see R5
                    end
                end
                default: begin
                    // pin and low-voltage resets keep the flags (see R3)
                    if (I_STATUS_WE) begin
                        O_STATUS         <= I_STATUS_WDATA; // see R1
                        O_TIMEOUT_FLAG   <= I_STATUS_WDATA[`RSC_STAT_TO_BIT];
                        O_POWERDOWN_FLAG <= I_STATUS_WDATA[`RSC_STAT_PDF_BIT];
                    end
                end
            endcase
        end
    end

    // registers cleared by every reset, retaining or not
    always @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_PROGRAM_COUNTER_LOW    <= `RSC_ZERO8;
            O_INTERRUPT_CONTROL_FOUR <= `RSC_ZERO4;
            O_OPTION_MAPPING_CONTROL <= `RSC_ZERO8;
            O_STACK_PTR              <= `RSC_STACK_TOP;
        end else if (any_evt) begin
            O_PROGRAM_COUNTER_LOW    <= `RSC_ZERO8; // see R11
            O_INTERRUPT_CONTROL_FOUR <= `RSC_ZERO4; // see R11
            O_OPTION_MAPPING_CONTROL <= `RSC_ZERO8; // see R11
            O_STACK_PTR              <= `RSC_STACK_TOP; // see R10 see R13
        end else begin
            // software loads outside reset cycles
            if (I_PC_LOAD) begin
                O_PROGRAM_COUNTER_LOW <= I_PC_WDATA;
            end
            if (I_SP_LOAD) begin
                O_STACK_PTR <= I_SP_WDATA;
            end
            if (I_OPT_MAP_WE) begin
                O_OPTION_MAPPING_CONTROL <= I_OPT_MAP_WDATA;
            end
            if (I_INT_EN_WE) begin
                O_INTERRUPT_CONTROL_FOUR <= I_INT_EN_WDATA[`RSC_ICF_MSB:0];
            end
        end
    end

    // registers defaulted unless retained by watchdog in low power
    always @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_INT_ENABLE          <= `RSC_ZERO8;
            O_TIMER_ON            <= `RSC_ZERO8;
            O_PORT_DIR            <= `RSC_PORT_DIR_IN;
            O_WATCHDOG_TIMER_CTRL <= `RSC_WDTC_DEF;
        end else if (apply_dflt) begin
            O_INT_ENABLE          <= `RSC_ZERO8; // see R6 see R11
            O_TIMER_ON            <= `RSC_ZERO8; // see R8
            O_PORT_DIR            <= `RSC_PORT_DIR_IN; // see R9
            O_WATCHDOG_TIMER_CTRL <= `RSC_WDTC_DEF; // see R7
        end else if (sw_open) begin
            // a retaining reset leaves this group untouched
            if (I_INT_EN_WE) begin
                O_INT_ENABLE <= I_INT_EN_WDATA;
            end
            if (I_TIMER_ON_WE) begin
                O_TIMER_ON <= I_TIMER_ON_WDATA;
            end
            if (I_PORT_DIR_WE) begin
                O_PORT_DIR <= I_PORT_DIR_WDATA;
            end
        end
    end

endmodule

// file: rsc_consts.vh
`ifndef RSC_CONSTS_VH
`define RSC_CONSTS_VH

// reset cause one-hot codes
`define RSC_CAUSE_POR       4'h1
`define RSC_CAUSE_PIN       4'h2
`define RSC_CAUSE_LVR       4'h4
`define RSC_CAUSE_WDT       4'h8

// status register bit positions
`define RSC_STAT_PDF_BIT    4
`define RSC_STAT_TO_BIT     5

// status reset value after power-on (only flag bits defined, others zero)
`define RSC_STAT_POR        8'h00

// register default values
`define RSC_ZERO8           8'h00
`define RSC_ONES8           8'hFF
`define RSC_ZERO4           4'h0
`define RSC_WDTC_DEF        8'h53
`define RSC_PORT_DIR_IN     8'hFF
`define RSC_STACK_TOP       4'h0

// selector encodings
`define RSC_SEL_NONE        2'h0
`define RSC_SEL_DEFAULT     2'h1
`define RSC_SEL_RETAIN      2'h2

// interrupt enable bits that also feed interrupt control four
`define RSC_ICF_MSB         3

`endif

// file: rsc_monitor.sv
module rsc_monitor (
    input wire       I_SYS_CLK,
    input wire       I_RST,
    input wire       I_POR,
    input wire       I_EXT_PIN_RST,
    input wire       I_LOW_VOLTAGE_RST,
    input wire       I_WDT_TIMEOUT,
    input wire       I_LOW_POWER_MODE,
    input wire [7:0] O_STATUS,
    input wire       O_TIMEOUT_FLAG,
    input wire       O_POWERDOWN_FLAG,
    input wire [7:0] O_INT_ENABLE,
    input wire [3:0] O_INTERRUPT_CONTROL_FOUR,
    input wire [7:0] O_TIMER_ON,
    input wire [7:0] O_PORT_DIR,
    input wire [7:0] O_OPTION_MAPPING_CONTROL,
    input wire [7:0] O_PROGRAM_COUNTER_LOW,
    input wire [3:0] O_STACK_PTR,
    input wire [7:0] O_WATCHDOG_TIMER_CTRL,
    input wire       O_WDT_CLEAR,
    input wire [1:0] O_RESET_SEL
);
    // one clock domain, reset acts as power-on
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);
    // flag outputs mirror the status bits
    a_flag_copy: assert property (O_TIMEOUT_FLAG == O_STATUS[5] && O_POWERDOWN_FLAG == O_STATUS[4])
        else $error("flag copies differ from status");
    a_sel_pulse: assert property (O_RESET_SEL != 2'h0 |=> O_RESET_SEL == 2'h0)
        else $error("selector longer than one cycle");
    a_clear_tied: assert property (O_WDT_CLEAR == (O_RESET_SEL == 2'h1))
        else $error("watchdog clear not tied to default selector");
    a_default_vals: assert property (O_RESET_SEL == 2'h1 |-> O_INT_ENABLE == 8'h00 && O_TIMER_ON == 8'h00
        && O_PORT_DIR == 8'hFF && O_WATCHDOG_TIMER_CTRL == 8'h53 && O_STACK_PTR == 4'h0)
        else $error("default values wrong");
    a_por_flags: assert property ($rose(I_POR) |-> ##[1:4] (O_RESET_SEL == 2'h1 && !O_TIMEOUT_FLAG
        && !O_POWERDOWN_FLAG))
        else $error("power-on did not clear flags");
    a_pin_keeps: assert property ($rose(I_EXT_PIN_RST) |-> ##[1:4] (O_RESET_SEL == 2'h1
        && $stable(O_TIMEOUT_FLAG) && $stable(O_POWERDOWN_FLAG)))
        else $error("pin reset changed flags");
    a_wdt_fast: assert property ($rose(I_WDT_TIMEOUT) && !I_LOW_POWER_MODE |-> ##[1:4] (O_RESET_SEL == 2'h1
        && O_TIMEOUT_FLAG && $stable(O_POWERDOWN_FLAG)))
        else $error("watchdog reset in fast mode wrong");
    a_wdt_sleep: assert property ($rose(I_WDT_TIMEOUT) && I_LOW_POWER_MODE |-> ##[1:4] (O_RESET_SEL == 2'h2
        && O_TIMEOUT_FLAG && O_POWERDOWN_FLAG && O_PROGRAM_COUNTER_LOW == 8'h00 && O_STACK_PTR == 4'h0))
        else $error("watchdog reset in sleep wrong");
    a_retain_keep: assert property (O_RESET_SEL == 2'h2 |-> $stable(O_INT_ENABLE) && $stable(O_TIMER_ON)
        && $stable(O_PORT_DIR) && $stable(O_WATCHDOG_TIMER_CTRL))
        else $error("retain reset changed registers");
    a_lvr_keeps: assert property ($rose(I_LOW_VOLTAGE_RST) |-> ##[1:4] (O_RESET_SEL == 2'h1
        && $stable(O_TIMEOUT_FLAG) && $stable(O_POWERDOWN_FLAG)))
        else $error("low-voltage reset changed flags");
    a_any_clears: assert property (O_RESET_SEL != 2'h0 |-> O_INTERRUPT_CONTROL_FOUR == 4'h0
        && O_OPTION_MAPPING_CONTROL == 8'h00 && O_PROGRAM_COUNTER_LOW == 8'h00)
        else $error("always-cleared registers not cleared");
    // main scenarios
    c_default: cover property (O_RESET_SEL == 2'h1);
    c_retain: cover property (O_RESET_SEL == 2'h2);
    c_por: cover property ($rose(I_POR));
endmodule

bind rsc_reset_state_controller rsc_monitor u_rsc_monitor (.*);

// file: tb.sv
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk = 0, rst = 1, lp = 0;
    logic [3:0] cause = 4'h0, sp, icf, o_sp, o_icf;
    logic [5:0] we = 6'h00;
    logic [7:0] wd = 8'h00, st, ie, tm, pd, om, pc, wc, o_st, o_ie, o_tm, o_pd, o_om, o_pc, o_wc;
    logic       to, pf, o_to, o_pf, o_clr;
    logic [1:0] o_sel;
    logic [31:0] rs = 32'hBB83B86B;
    int         failures = 0, checked = 0, cyc = 0;
    rsc_reset_state_controller u_rsc_reset_state_controller (.I_SYS_CLK(clk), .I_RST(rst),
        .I_POR(cause[0]), .I_EXT_PIN_RST(cause[1]), .I_LOW_VOLTAGE_RST(cause[2]),
        .I_WDT_TIMEOUT(cause[3]), .I_LOW_POWER_MODE(lp), .I_STATUS_WE(we[5]), .I_STATUS_WDATA(wd),
        .I_INT_EN_WE(we[0]), .I_INT_EN_WDATA(wd), .I_TIMER_ON_WE(we[1]), .I_TIMER_ON_WDATA(wd),
        .I_PORT_DIR_WE(we[2]), .I_PORT_DIR_WDATA(wd), .I_OPT_MAP_WE(we[3]), .I_OPT_MAP_WDATA(wd),
        .I_PC_LOAD(we[4]), .I_PC_WDATA(wd), .I_SP_LOAD(we[4]), .I_SP_WDATA(wd[3:0]),
        .O_STATUS(o_st), .O_TIMEOUT_FLAG(o_to), .O_POWERDOWN_FLAG(o_pf), .O_INT_ENABLE(o_ie),
        .O_INTERRUPT_CONTROL_FOUR(o_icf), .O_TIMER_ON(o_tm), .O_PORT_DIR(o_pd),
        .O_OPTION_MAPPING_CONTROL(o_om), .O_PROGRAM_COUNTER_LOW(o_pc), .O_STACK_PTR(o_sp),
        .O_WATCHDOG_TIMER_CTRL(o_wc), .O_WDT_CLEAR(o_clr), .O_RESET_SEL(o_sel));
    // free-running clock and hang guard
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            final_report();
        end
    end
    function automatic logic [7:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs[7:0];
    endfunction
    task automatic cmp(string n, logic [7:0] e, logic [7:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // model state after a power-on style reset
    task automatic defaults(logic por);
        if (por) {to, pf, st} = 10'h000;
        {ie, icf, tm, pd, om, pc, sp, wc} = {8'h00, 4'h0, 8'h00, 8'hFF, 8'h00, 8'h00, 4'h0, 8'h53};
    endtask
    task automatic chk_all();
        cmp("flags", {to, pf}, {o_to, o_pf});
        cmp("status_flags", {to, pf}, o_st[5:4]);
        cmp("status_rest", {st[7:6], st[3:0]}, {o_st[7:6], o_st[3:0]});
        cmp("int_en", ie, o_ie);
        cmp("int_ctl4", icf, o_icf);
        cmp("timer_on", tm, o_tm);
        cmp("port_dir", pd, o_pd);
        cmp("opt_map", om, o_om);
        cmp("pc_low", pc, o_pc);
        cmp("stack_ptr", sp, o_sp);
        cmp("wdt_ctl", wc, o_wc);
    endtask
    // software write of a random value to one register group
    task automatic wr(int k);
        wd = xs();
        we = 6'h01 << k;
        @(posedge clk);
        #1;
        case (k)
            0: {ie, icf} = {wd, wd[3:0]};
            1: tm = wd;
            2: pd = wd;
            3: om = wd;
            4: {pc, sp} = {wd, wd[3:0]};
            default: {st, to, pf} = {wd, wd[5], wd[4]};
        endcase
    endtask
    // raise one reset cause in the given mode and check the applied state
    task automatic ev(int c, logic m);
        int n;
        logic [1:0] es;
        we = 6'h00;
        lp = m;
        repeat (4) @(posedge clk);
        #1 cause[c] = 1'b1;
        n = 0;
        // a status write in the event cycle must lose to power-on and watchdog
        while (o_sel === 2'h0 && n < 8) begin
            @(posedge clk);
            #1 n++;
            if (n == 2 && o_sel === 2'h0 && (c == 0 || c == 3)) begin
                wd = xs();
                we = 6'h20;
            end
        end
        we = 6'h00;
        es = 2'h1;
        if (c == 3 && m) begin
            {to, pf, pc, sp, icf, om, es} = {2'b11, 8'h00, 4'h0, 4'h0, 8'h00, 2'h2};
        end else begin
            defaults(c == 0);
            if (c == 3) to = 1'b1;
        end
        cmp("reset_sel", es, o_sel);
        cmp("wdt_clear", es == 2'h1, o_clr);
        chk_all();
        cause = 4'h0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        #1 rst = 0;
        defaults(1'b1);
        chk_all();
        for (int i = 0; i < 16; i++) begin
            for (int k = 0; k < 6; k++) wr(k);
            ev(i % 4, (i % 4 == 1 || i % 4 == 2) ? 1'b0 : i[2]);
            $display("test %0d cause %0d done", i, i % 4);
        end
        rst = 1;
        @(posedge clk);
        #1 rst = 0;
        defaults(1'b1);
        chk_all();
        final_report();
    end
endmodule
